// ### hdl/stw_map.svh
// Register offsets, field positions, reset values for the secondary timer
// Assumes inclusion by the top module only
`ifndef STW_MAP_SVH
`define STW_MAP_SVH

`define STW_OFF_TLOW 8'h00
`define STW_OFF_THIGH 8'h04
`define STW_OFF_TCTRL 8'h08
`define STW_OFF_OCTRL 8'h0c
`define STW_OFF_IRQ 8'h10

`define STW_TC_WIDE 7
`define STW_TC_ACTIVE 6
`define STW_TC_PS_HI 5
`define STW_TC_PS_LO 4
`define STW_TC_OSCEN 3
`define STW_TC_ON 0

`define STW_OC_IDLE 7
`define STW_OC_LPOSC 2
`define STW_OC_SEL_HI 1
`define STW_OC_SEL_LO 0

`define STW_IRQ_FLAG 0
`define STW_IRQ_EN 1

`define STW_SEL_SECONDARY 2'b01
`define STW_TCTRL_RST 8'h00
`define STW_OCTRL_RST 8'h00

`endif

// ### hdl/stw_pkg.sv
// Types for the secondary timer block
// Assumes the map header supplies all numeric constants
package stw_pkg;

  // ==========================================
  // Power-mode states
  typedef enum logic [1:0] {
    STW_PM_PRIMARY = 2'b00,
    STW_PM_SECONDARY_RUN_MODE = 2'b01,
    STW_PM_SECONDARY_IDLE_MODE = 2'b10
  } stw_pm_t;

  // ==========================================
  // Latched AHB address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } stw_aph_t;

  // ==========================================
  // State of the top module apart from the synchronisers and the edge detector
  typedef struct packed {
    logic [15:0] count;
    logic [7:0] hold;
    logic [7:0] prescale;
    logic [7:0] tctrl;
    logic [7:0] octrl;
    logic ovf_flag;
    logic ovf_en;
    stw_pm_t pm;
    stw_aph_t aph;
    logic [31:0] rdata;
  } stw_state_t;

endpackage

// ### hdl/stw_sync.sv
// Two-flop synchroniser for a level from outside the clock domain
// Assumes hclk domain and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module stw_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic async_in,
  output logic sync_out
);

  logic [1:0] sync_q;

  // ==========================================
  // Second flop alone reads the first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_q <= 2'h0;
    end else if (clk_en) begin
      sync_q <= {sync_q[0], async_in};
    end
  end

  assign sync_out = sync_q[1];

endmodule

`default_nettype wire

// ### hdl/stw_top.sv
// Secondary timer with wide access, oscillator control and clock status
// Assumes an AHB-Lite master, one clock hclk, crystal pins handled by an analog cell
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

`include "stw_map.svh"

// Summary of operation
// - Wide-access bit maps high-byte address onto a holding register.
// - Low-byte read in wide mode copies live high byte into holding register.
// - Low-byte write in wide mode loads high byte from holding register.
// - In wide mode the live high byte is never touched directly.
// - Low-byte write clears prescaler; high-byte write leaves it alone.
// - Crystal oscillator runs only while its enable bit is set.
// - Oscillator keeps running in every power-managed mode.
// - Clock select 01 enters secondary run mode on the timer oscillator.
// - Sleep with idle bit clear on timer oscillator enters secondary idle.
// - Secondary-clock-active bit follows whether the timer oscillator clocks the system.
// - After oscillator failure, status bit shows the source actually in use.
// - Low-power bit selects low-power oscillator mode; higher power by default.
// - Overflow interrupt request raised only while its enable bit is set.
module stw_top
  import stw_pkg::*;
#(
  parameter int PS_WIDTH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sleep_req,
  input wire logic osc_fail,
  input wire logic ext_tick,
  output logic osc_enable,
  output logic osc_low_power,
  output logic sys_clk_from_secondary,
  output logic cpu_halted,
  output logic overflow_irq
);

  stw_state_t s_q;
  stw_state_t s_d;
  logic osc_fail_s;
  logic tick_s;
  logic tick_d1_q;
  logic tick_rise;
  logic wide;
  logic dp_wr;
  logic dp_rd;
  logic [7:0] wbyte;
  logic [1:0] psel;
  logic [7:0] ps_limit;
  logic on_secondary;
  logic ovf_evt;

  // ==========================================
  // Synchronisers for pin-side inputs
  stw_sync u_sync_fail (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .async_in(osc_fail),
    .sync_out(osc_fail_s)
  );

  stw_sync u_sync_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .async_in(ext_tick),
    .sync_out(tick_s)
  );

  // Edge detector behind the synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_d1_q <= 1'b0;
    end else if (clk_en) begin
      tick_d1_q <= tick_s;
    end
  end

  // ==========================================
  // Decode helpers
  assign tick_rise = tick_s & ~tick_d1_q;
  assign wide = s_q.tctrl[`STW_TC_WIDE];
  assign dp_wr = s_q.aph.valid & s_q.aph.write;
  assign dp_rd = s_q.aph.valid & ~s_q.aph.write;
  assign wbyte = hwdata[7:0];
  assign psel = s_q.tctrl[`STW_TC_PS_HI:`STW_TC_PS_LO];
  assign ps_limit = 8'(({7'h00, 1'b1} << psel) - 8'h01);
  // Rollover event this cycle, so a same-cycle clear cannot hide it
  assign ovf_evt = s_q.tctrl[`STW_TC_ON] & tick_rise & (s_q.prescale >= ps_limit)
    & (s_q.count == 16'hffff);
  // Oscillator supplies the clock only when running and not failed
  assign on_secondary = (s_q.pm != STW_PM_PRIMARY) & s_q.tctrl[`STW_TC_OSCEN]
    & ~osc_fail_s;

  // ==========================================
  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Address phase capture
    if (hready) begin
      s_d.aph.valid = hsel & htrans[1];
      s_d.aph.write = hwrite;
      s_d.aph.addr = haddr[7:0];
    end
    // Counting with prescaler, gated by timer-on
    if (s_q.tctrl[`STW_TC_ON] && tick_rise) begin
      if (s_q.prescale >= ps_limit) begin
        s_d.prescale = 8'h00;
        s_d.count = s_q.count + 16'h0001;
        if (s_q.count == 16'hffff) begin
          s_d.ovf_flag = 1'b1;
        end
      end else begin
        s_d.prescale = s_q.prescale + 8'h01;
      end
    end
    // Register reads with side effects
    if (dp_rd && s_q.aph.addr == `STW_OFF_TLOW && wide) begin
      s_d.hold = s_q.count[15:8];
    end
    // Register writes
    if (dp_wr) begin
      case (s_q.aph.addr)
        `STW_OFF_TLOW: begin
          s_d.prescale = 8'h00;
          if (wide) begin
            s_d.count = {s_q.hold, wbyte};
          end else begin
            s_d.count[7:0] = wbyte;
          end
        end
        `STW_OFF_THIGH: begin
          if (wide) begin
            s_d.hold = wbyte;
          end else begin
            s_d.count[15:8] = wbyte;
          end
        end
        `STW_OFF_TCTRL: begin
          s_d.tctrl = wbyte;
          s_d.tctrl[`STW_TC_ACTIVE] = s_q.tctrl[`STW_TC_ACTIVE];
        end
        `STW_OFF_OCTRL: begin
          s_d.octrl = wbyte;
        end
        `STW_OFF_IRQ: begin
          s_d.ovf_en = hwdata[`STW_IRQ_EN];
          // Set wins over a clear in the same cycle
          if (!hwdata[`STW_IRQ_FLAG] && !ovf_evt) begin
            s_d.ovf_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Power-mode sequencing
    case (s_q.pm)
      STW_PM_PRIMARY: begin
        if (s_q.octrl[`STW_OC_SEL_HI:`STW_OC_SEL_LO] == `STW_SEL_SECONDARY) begin
          s_d.pm = STW_PM_SECONDARY_RUN_MODE;
        end
      end
      STW_PM_SECONDARY_RUN_MODE: begin
        if (s_q.octrl[`STW_OC_SEL_HI:`STW_OC_SEL_LO] != `STW_SEL_SECONDARY) begin
          s_d.pm = STW_PM_PRIMARY;
        end else if (sleep_req && !s_q.octrl[`STW_OC_IDLE]) begin
          s_d.pm = STW_PM_SECONDARY_IDLE_MODE;
        end
      end
      STW_PM_SECONDARY_IDLE_MODE: begin
        if (!sleep_req) begin
          s_d.pm = STW_PM_SECONDARY_RUN_MODE;
        end
      end
      default: begin
        s_d.pm = STW_PM_PRIMARY;
      end
    endcase
    // Status bit tracks the real clock source
    s_d.tctrl[`STW_TC_ACTIVE] = on_secondary;
    // Read data for the data phase
    s_d.rdata = 32'h0000_0000;
    if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        `STW_OFF_TLOW: s_d.rdata = {24'h000000, s_d.count[7:0]};
        `STW_OFF_THIGH: begin
          if (s_d.tctrl[`STW_TC_WIDE]) begin
            s_d.rdata = {24'h000000, s_d.hold};
          end else begin
            s_d.rdata = {24'h000000, s_d.count[15:8]};
          end
        end
        `STW_OFF_TCTRL: s_d.rdata = {24'h000000, s_d.tctrl};
        `STW_OFF_OCTRL: s_d.rdata = {24'h000000, s_d.octrl};
        `STW_OFF_IRQ: s_d.rdata = {30'h00000000, s_d.ovf_en, s_d.ovf_flag};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '{count: 16'h0000, hold: 8'h00, prescale: 8'h00,
        tctrl: `STW_TCTRL_RST, octrl: `STW_OCTRL_RST, ovf_flag: 1'b0,
        ovf_en: 1'b0, pm: STW_PM_PRIMARY, aph: '0, rdata: 32'h0000_0000};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // Outputs
  assign hreadyout = 1'b1;  // Zero wait states
  assign hresp = 1'b0;  // Always OKAY
  assign hrdata = s_q.rdata;
  // Enable follows its bit alone, independent of power mode
  assign osc_enable = s_q.tctrl[`STW_TC_OSCEN];
  assign osc_low_power = s_q.octrl[`STW_OC_LPOSC];
  assign sys_clk_from_secondary = s_q.tctrl[`STW_TC_ACTIVE];
  assign cpu_halted = (s_q.pm == STW_PM_SECONDARY_IDLE_MODE);
  assign overflow_irq = s_q.ovf_flag & s_q.ovf_en;

endmodule

`default_nettype wire

// ### tb/stw_properties.sv
// Concurrent checks on the secondary timer ports
// Assumes binding onto stw_top with a word-only, single-transfer master
`timescale 1ns/1ps
`default_nettype none

module stw_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic sleep_req,
  input wire logic osc_fail,
  input wire logic osc_enable,
  input wire logic osc_low_power,
  input wire logic sys_clk_from_secondary,
  input wire logic cpu_halted,
  input wire logic overflow_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] ad_q;
  logic wr_q, rd_q, en_q;
  logic take;
  // ==========================================
  // Track data phases and the mirrored enable
  assign take = hsel && hready && htrans[1] && clk_en;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      ad_q <= 8'h00;
      en_q <= 1'b0;
    end else begin
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite;
      ad_q <= haddr[7:0];
      if (wr_q && ad_q == 8'h10) en_q <= hwdata[1];
    end
  end
  sequence wr_at(logic [7:0] a);
    wr_q && ad_q == a;
  endsequence
  // ==========================================
  // Properties
  ahb_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
  rdata_idle_a: assert property (!rd_q |-> hrdata == 32'h0) else $error("read data outside phase");
  osc_en_a: assert property (wr_at(8'h08) |=> osc_enable == $past(hwdata[3]))
    else $error("oscillator enable wrong");
  low_power_a: assert property (wr_at(8'h0c) |=> osc_low_power == $past(hwdata[2]))
    else $error("low power select wrong");
  irq_mask_a: assert property (overflow_irq |-> en_q || $past(en_q))
    else $error("irq while masked");
  halt_cause_a: assert property ($rose(cpu_halted) |-> $past(sleep_req) || $past(sleep_req, 2))
    else $error("halt without sleep");
  active_drop_a: assert property ($fell(osc_enable) |-> ##[0:2] !sys_clk_from_secondary)
    else $error("active stays without oscillator");
  fail_clear_a: assert property (osc_fail [*8] |-> !sys_clk_from_secondary)
    else $error("active stays after failure");
endmodule

bind stw_top stw_properties u_stw_properties (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .sleep_req(sleep_req), .osc_fail(osc_fail), .osc_enable(osc_enable),
  .osc_low_power(osc_low_power), .sys_clk_from_secondary(sys_clk_from_secondary),
  .cpu_halted(cpu_halted), .overflow_irq(overflow_irq));

`default_nettype wire

// ### tb/secondary_timer_wide_access_bench.sv
// Self-checking bench for the secondary timer
// Assumes stw_pkg, stw_top and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module secondary_timer_wide_access_bench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sleep_req = 0, osc_fail = 0, ext_tick = 0;
  logic clk_en = 1;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic hreadyout, hresp, osc_enable, osc_low_power, sys_clk_from_secondary, cpu_halted;
  logic overflow_irq;
  logic [31:0] r;
  int err_count = 0, samples_checked = 0, seed = 32'hc964, m_cnt, i;
  // Clock and design
  initial forever #5 hclk = ~hclk;
  stw_top u_stw_top (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sleep_req,
    .osc_fail, .ext_tick, .osc_enable, .osc_low_power, .sys_clk_from_secondary, .cpu_halted,
    .overflow_irq);
  // ==========================================
  // Bus and check tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wait_rdy(inout int n);
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (n >= 64) begin
      err_count++;
      report_and_stop;
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy(n);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    wait_rdy(n);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk($sformatf("offset %h", a), {24'h0, e}, q);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      ext_tick <= 1'b1;
      repeat (4) @(posedge hclk);
      ext_tick <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    repeat (4) @(posedge hclk);
  endtask
  // Hang guard
  initial begin
    #500us;
    err_count++;
    report_and_stop;
  end
  // ==========================================
  // Scenarios
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    for (i = 0; i < 6; i++) rd(8'(i * 4), 8'h00);
    wr(8'h14, 8'hff);
    rd(8'h14, 8'h00);
    $display("test reset done");
    r = $random(seed);
    wr(8'h00, r[7:0]);
    wr(8'h04, r[15:8]);
    rd(8'h00, r[7:0]);
    rd(8'h04, r[15:8]);
    $display("test direct done");
    // Holding register redirects high byte
    wr(8'h08, 8'h80);
    wr(8'h04, r[23:16]);
    rd(8'h04, r[23:16]);
    wr(8'h08, 8'h00);
    rd(8'h04, r[15:8]);
    wr(8'h08, 8'h80);
    wr(8'h00, r[31:24]);
    wr(8'h04, ~r[23:16]);
    rd(8'h00, r[31:24]);
    rd(8'h04, r[23:16]);
    wr(8'h08, 8'h00);
    rd(8'h04, r[23:16]);
    $display("test wide done");
    // Rollover and interrupt mask
    wr(8'h00, 8'hfe);
    wr(8'h04, 8'hff);
    wr(8'h08, 8'h01);
    ticks(2);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h10, 8'h01);
    chk("irq masked", 32'h0, {31'h0, overflow_irq});
    wr(8'h10, 8'h03);
    repeat (2) @(posedge hclk);
    chk("irq on", 32'h1, {31'h0, overflow_irq});
    wr(8'h10, 8'h02);
    repeat (2) @(posedge hclk);
    chk("irq clear", 32'h0, {31'h0, overflow_irq});
    $display("test overflow done");
    // Prescaler kept by high write, cleared by low write
    m_cnt = 0;
    wr(8'h08, 8'h11);
    ticks(1);
    wr(8'h04, 8'h00);
    ticks(1);
    m_cnt++;
    rd(8'h00, 8'(m_cnt));
    ticks(1);
    wr(8'h00, 8'h10);
    ticks(1);
    rd(8'h00, 8'h10);
    // Clock enable low freezes the counter and ignores the tick
    wr(8'h08, 8'h01);
    clk_en <= 1'b0;
    ticks(1);
    clk_en <= 1'b1;
    rd(8'h00, 8'h10);
    ticks(1);
    rd(8'h00, 8'h11);
    $display("test prescale done");
    // Oscillator, modes and status
    wr(8'h08, 8'h08);
    wr(8'h0c, 8'h05);
    repeat (3) @(posedge hclk);
    chk("osc enable", 32'h1, {31'h0, osc_enable});
    chk("low power", 32'h1, {31'h0, osc_low_power});
    chk("secondary", 32'h1, {31'h0, sys_clk_from_secondary});
    rd(8'h08, 8'h48);
    // Idle bit set: sleep must not enter secondary idle
    wr(8'h0c, 8'h85);
    sleep_req <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("no halt", 32'h0, {31'h0, cpu_halted});
    wr(8'h0c, 8'h05);
    sleep_req <= 1'b1;
    repeat (4) @(posedge hclk);
    chk("halted", 32'h1, {31'h0, cpu_halted});
    chk("osc in idle", 32'h1, {31'h0, osc_enable});
    osc_fail <= 1'b1;
    repeat (10) @(posedge hclk);
    chk("failed", 32'h0, {31'h0, sys_clk_from_secondary});
    osc_fail <= 1'b0;
    sleep_req <= 1'b0;
    wr(8'h08, 8'h00);
    repeat (3) @(posedge hclk);
    chk("osc off", 32'h0, {31'h0, osc_enable});
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h0c, 8'h00);
    $display("test oscillator done");
    report_and_stop;
  end
endmodule

`default_nettype wire
